//--- hdl/adc_sample_correction_path.sv
// Purpose: digital back end of a multichannel delta-sigma converter
// Assumes: i_raw_data holds the decimator outputs on i_clock; master clock below 25 MHz
// Notes:   registers on classic Wishbone; frame = status word then one word per channel
`timescale 1ns/1ps
module adc_sample_correction_path #(
   parameter int NUM_CH     = adc_corr_pkg::NUM_CH,
   parameter int FIFO_DEPTH = adc_corr_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                             i_clock,
   input  wire logic                             i_rst,
   // wishbone slave
   input  wire logic                             i_wb_cyc,
   input  wire logic                             i_wb_stb,
   input  wire logic                             i_wb_we,
   input  wire logic [adc_corr_pkg::ADR_W-1:0]   i_wb_adr,
   input  wire logic [3:0]                       i_wb_sel,
   input  wire logic [31:0]                      i_wb_dat,
   output logic      [31:0]                      o_wb_dat,
   output logic                                  o_wb_ack,
   // device pins
   input  wire logic                             i_master_clock_input,
   input  wire logic                             i_spi_sclk,
   input  wire logic                             i_spi_cs_n,
   output logic                                  o_spi_miso,
   output logic                                  o_spi_miso_oe_n,
   output logic                                  o_sample_ready_n,
   // converter side
   input  wire logic [NUM_CH-1:0][adc_corr_pkg::WORD_W-1:0] i_raw_data,
   output logic      [NUM_CH-1:0][adc_corr_pkg::PGA_W-1:0]  o_pga_gain,
   output logic      [NUM_CH-1:0][1:0]           o_chan_mux,
   output logic      [NUM_CH-1:0]                o_chan_enable,
   output adc_corr_pkg::power_mode_t             o_power_mode,
   output logic                                  o_irq
);
   localparam int W     = adc_corr_pkg::WORD_W;
   localparam int CW    = adc_corr_pkg::CNT_W;
   localparam int DW    = NUM_CH * W;
   localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int CNT_F = $clog2(FIFO_DEPTH + 1);
   localparam logic [CNT_F-1:0] FULL = CNT_F'(FIFO_DEPTH);

   if (NUM_CH < 1 || NUM_CH > 8 || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad
      $error("unsupported channel count or fifo depth");
   end

   // registers
   logic [31:0]                  clock_q;
   logic [31:0]                  pga_a_q;
   logic [31:0]                  pga_b_q;
   logic [adc_corr_pkg::IRQ_W-1:0] irq_stat_q;
   logic [adc_corr_pkg::IRQ_W-1:0] irq_mask_q;
   adc_corr_pkg::chan_cfg_t      cfg_q [NUM_CH];
   adc_corr_pkg::chan_cal_t      cal_q [NUM_CH];

   // bus decode
   wire logic       req      = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire logic       wr       = req & i_wb_we;
   wire logic [7:0] ch_rel   = i_wb_adr - adc_corr_pkg::OFF_CH_BASE;
   wire logic [2:0] ch_idx   = 3'(ch_rel >> adc_corr_pkg::CH_SHIFT);
   wire logic [4:0] ch_off   = ch_rel[4:0];
   wire logic       ch_hit   = (i_wb_adr >= adc_corr_pkg::OFF_CH_BASE) && (ch_idx < 3'(NUM_CH));
   wire logic       we_clock = wr && i_wb_adr == adc_corr_pkg::OFF_CLOCK;
   wire logic       we_pga_a = wr && i_wb_adr == adc_corr_pkg::OFF_PGA_A;
   wire logic       we_pga_b = wr && i_wb_adr == adc_corr_pkg::OFF_PGA_B;
   wire logic       we_stat  = wr && i_wb_adr == adc_corr_pkg::OFF_IRQ_STAT;
   wire logic       we_mask  = wr && i_wb_adr == adc_corr_pkg::OFF_IRQ_MASK;
   wire logic       we_ch    = wr && ch_hit;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction : merge

   wire logic [31:0] wdat_clock = merge(clock_q, i_wb_dat, i_wb_sel);
   wire logic [31:0] wdat_pga_a = merge(pga_a_q, i_wb_dat, i_wb_sel);
   wire logic [31:0] wdat_pga_b = merge(pga_b_q, i_wb_dat, i_wb_sel);

   // clock register fields
   wire logic [CW-1:0]     oversampling_ratio     = adc_corr_pkg::osr_of(clock_q[adc_corr_pkg::CLK_OSR_LSB +: 3]); // RQ6
   wire logic [NUM_CH-1:0] chan_en = clock_q[adc_corr_pkg::CLK_EN_LSB +: NUM_CH];

   // master clock: three-stage sync, divide by two for the modulator tick
   logic [2:0]    mclk_s;
   logic          mclk_q;
   logic          mod_div_q;
   logic [CW-1:0] mod_cnt_q;
   // a level counts once the last two stages agree
   wire logic     mclk_new   = (mclk_s[1] == mclk_s[2]) ? mclk_s[2] : mclk_q;
   wire logic     mclk_rise  = mclk_new & ~mclk_q;
   wire logic     mod_tick   = mclk_rise & mod_div_q;                      // RQ1
   wire logic     period_end = mod_tick && (mod_cnt_q >= oversampling_ratio - 1'b1);      // RQ2 RQ17

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         mclk_s    <= '0;
         mclk_q    <= 1'b0;
         mod_div_q <= 1'b0;
         mod_cnt_q <= '0;
      end else begin
         mclk_s    <= {mclk_s[1:0], i_master_clock_input};
         mclk_q    <= mclk_new;
         mod_div_q <= mod_div_q ^ mclk_rise;
         if (period_end) begin
            mod_cnt_q <= '0;
         end else if (mod_tick) begin
            mod_cnt_q <= mod_cnt_q + 1'b1;
         end
      end
   end

   // per-channel capture at its phase delay, then correction
   logic [DW-1:0] corr;
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      // a phase at or above the ratio never captures
      wire logic cap = mod_tick && (mod_cnt_q == CW'(cfg_q[c].phase));      // RQ12
      chan_correct u_corr (
         .i_clock (i_clock),
         .i_rst   (i_rst),
         .i_valid (cap),
         .i_raw   (i_raw_data[c]),
         .i_cal   (cal_q[c]),
         .i_dcblk (cfg_q[c].dcblk),
         .o_data  (corr[c*W +: W])
      );
      assign o_pga_gain[c] = (c < adc_corr_pkg::PGA_PER_REG)
                           ? pga_a_q[c*adc_corr_pkg::PGA_STRIDE +: adc_corr_pkg::PGA_W]
                           : pga_b_q[(c-adc_corr_pkg::PGA_PER_REG)*adc_corr_pkg::PGA_STRIDE +: adc_corr_pkg::PGA_W]; // RQ7
      assign o_chan_mux[c]    = cfg_q[c].mux;                               // RQ8
      assign o_chan_enable[c] = chan_en[c];
   end
   assign o_power_mode = adc_corr_pkg::power_mode_t'(clock_q[adc_corr_pkg::CLK_PWR_LSB +: 2]);

   // output fifo
   logic [DW-1:0]    fifo_mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_F-1:0] count_q;
   logic [1:0]       push_dly_q;
   logic             arm_q;
   logic             ovf_q;
   logic             frame_start;
   logic             frame_done;
   logic [DW-1:0]    en_mask;
   for (genvar c = 0; c < NUM_CH; c++) begin : g_mask
      assign en_mask[c*W +: W] = {W{chan_en[c]}};
   end
   wire logic       push     = push_dly_q[1];
   wire logic       pop      = frame_done && count_q != '0;
   wire logic       overflow = push && !pop && count_q == FULL;             // RQ14
   wire logic       push_ok  = push && !overflow;
   wire logic [W-1:0] status_word = W'({count_q, ovf_q, chan_en});
   // on the wire: status, then top channel first
   wire logic [adc_corr_pkg::FRAME_W-1:0] frame = {status_word, fifo_mem[rd_ptr_q]};

   always_ff @(posedge i_clock) begin
      if (push) begin
         fifo_mem[wr_ptr_q] <= corr & en_mask;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         wr_ptr_q   <= '0;
         rd_ptr_q   <= '0;
         count_q    <= '0;
         push_dly_q <= '0;
         ovf_q      <= 1'b0;
      end else begin
         push_dly_q <= {push_dly_q[0], period_end};
         if (overflow) begin
            // keep just the newest result
            wr_ptr_q <= wr_ptr_q + PTR_W'(1'b1);
            rd_ptr_q <= wr_ptr_q;
            count_q  <= CNT_F'(1'b1);
            ovf_q    <= 1'b1;
         end else begin
            wr_ptr_q <= wr_ptr_q + PTR_W'(push_ok);
            rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
            count_q  <= count_q + CNT_F'(push_ok) - CNT_F'(pop);
            if (pop) begin
               ovf_q <= 1'b0;
            end
         end
      end
   end

   // ready_n: high one cycle then falling edge per new sample, none for a sample that overflows
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_sample_ready_n <= 1'b1;
         arm_q            <= 1'b0;
      end else if (overflow || frame_start) begin
         o_sample_ready_n <= 1'b1;                                          // RQ14
         arm_q            <= 1'b0;
      end else if (push_ok || (pop && count_q > 1)) begin
         o_sample_ready_n <= 1'b1;
         arm_q            <= 1'b1;
      end else if (arm_q) begin
         o_sample_ready_n <= 1'b0;                                          // RQ3
         arm_q            <= 1'b0;
      end
   end

   spi_frame_tx #(
      .FRAME_W (adc_corr_pkg::FRAME_W)
   ) u_spi (
      .i_clock     (i_clock),
      .i_rst       (i_rst),
      .i_sclk      (i_spi_sclk),
      .i_cs_n      (i_spi_cs_n),
      .o_miso      (o_spi_miso),
      .o_miso_oe_n (o_spi_miso_oe_n),
      .i_frame     (frame),
      .o_start     (frame_start),
      .o_done      (frame_done)
   );

   // interrupt events, set wins over write-one-to-clear
   wire logic [adc_corr_pkg::IRQ_W-1:0] irq_set = {frame_done, overflow, push_ok};
   wire logic [adc_corr_pkg::IRQ_W-1:0] irq_clr = we_stat ? i_wb_dat[adc_corr_pkg::IRQ_W-1:0] : '0;

   // register writes
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         clock_q    <= adc_corr_pkg::CLOCK_RESET;
         pga_a_q    <= '0;
         pga_b_q    <= '0;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         o_irq      <= 1'b0;
         for (int c = 0; c < NUM_CH; c++) begin
            cfg_q[c] <= '0;
            cal_q[c] <= '{offset: '0, gain: {adc_corr_pkg::GAIN_HI_RST, 8'h00}};
         end
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         o_irq      <= |(irq_stat_q & irq_mask_q);
         if (we_clock) begin
            clock_q <= wdat_clock;                                          // RQ6
         end
         if (we_pga_a) begin
            pga_a_q <= wdat_pga_a;                                          // RQ7
         end
         if (we_pga_b) begin
            pga_b_q <= wdat_pga_b;
         end
         if (we_mask) begin
            irq_mask_q <= i_wb_dat[adc_corr_pkg::IRQ_W-1:0];
         end
         if (we_ch) begin
            case (ch_off)
               adc_corr_pkg::CH_CFG: begin
                  cfg_q[ch_idx] <= '{phase: i_wb_dat[adc_corr_pkg::CFG_PH_LSB +: adc_corr_pkg::PHASE_W],
                                     dcblk: i_wb_dat[adc_corr_pkg::CFG_DCB_BIT],
                                     mux:   i_wb_dat[adc_corr_pkg::CFG_MUX_LSB +: 2]}; // RQ8 RQ17
               end
               adc_corr_pkg::CH_OFS_HI:  cal_q[ch_idx].offset[W-1:8] <= i_wb_dat[15:0]; // RQ9
               adc_corr_pkg::CH_OFS_LO:  cal_q[ch_idx].offset[7:0]   <= i_wb_dat[7:0];
               adc_corr_pkg::CH_GAIN_HI: cal_q[ch_idx].gain[W-1:8]   <= i_wb_dat[15:0]; // RQ10
               adc_corr_pkg::CH_GAIN_LO: cal_q[ch_idx].gain[7:0]     <= i_wb_dat[7:0];
               default: ;
            endcase
         end
      end
   end

   // read mux
   adc_corr_pkg::chan_cfg_t sel_cfg;
   adc_corr_pkg::chan_cal_t sel_cal;
   assign sel_cfg = cfg_q[ch_idx < 3'(NUM_CH) ? ch_idx : 3'h0];
   assign sel_cal = cal_q[ch_idx < 3'(NUM_CH) ? ch_idx : 3'h0];
   wire logic [31:0] ch_rd =
        (ch_off == adc_corr_pkg::CH_CFG)     ? 32'({sel_cfg.phase, 3'h0, sel_cfg.dcblk, sel_cfg.mux}) :
        (ch_off == adc_corr_pkg::CH_OFS_HI)  ? 32'(sel_cal.offset[W-1:8]) :
        (ch_off == adc_corr_pkg::CH_OFS_LO)  ? 32'(sel_cal.offset[7:0]) :
        (ch_off == adc_corr_pkg::CH_GAIN_HI) ? 32'(sel_cal.gain[W-1:8]) :
        (ch_off == adc_corr_pkg::CH_GAIN_LO) ? 32'(sel_cal.gain[7:0]) : 32'h00000000;
   wire logic [31:0] rd_data =
        ch_hit                                    ? ch_rd :
        (i_wb_adr == adc_corr_pkg::OFF_CLOCK)    ? clock_q :
        (i_wb_adr == adc_corr_pkg::OFF_PGA_A)    ? pga_a_q :
        (i_wb_adr == adc_corr_pkg::OFF_PGA_B)    ? pga_b_q :
        (i_wb_adr == adc_corr_pkg::OFF_IRQ_STAT) ? 32'(irq_stat_q) :
        (i_wb_adr == adc_corr_pkg::OFF_IRQ_MASK) ? 32'(irq_mask_q) :
        (i_wb_adr == adc_corr_pkg::OFF_STATE)    ? 32'({count_q, ovf_q, mod_cnt_q}) : 32'h00000000;

   // ack one edge after each request, for one cycle
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end else begin
         o_wb_ack <= req;
         o_wb_dat <= req ? rd_data : 32'h00000000;
      end
   end
endmodule : adc_sample_correction_path

//--- common/adc_corr_pkg.sv
// Purpose: shared constants, register map and types of the sample correction path
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes:   Functional notes below
//
// Functional notes
// [RQ1] modulator clock is master clock over two
// [RQ2] one sample per oversampling ratio modulator clocks
// [RQ3] new samples signalled by falling ready_n edge
// [RQ4] serial port clock idles low, sampled second edge
// [RQ5] host clocks whole frame within sample period
// [RQ6] clock register: ratio, channel enables, power mode
// [RQ7] two gain registers cover all channel gains
// [RQ8] channel register: input mux and phase delay
// [RQ9] stored offset subtracted from every result; the code skips it when dcblk is set
// [RQ10] every result multiplied by gain trim
// [RQ11] host programs reciprocal of measured gain
// [RQ12] phase delay shifts channel sampling instant live
// [RQ13] dc blocking filter replaces offset subtraction
// [RQ14] two-entry output fifo, overflow halves ready rate
// [RQ15] host reads every frame word or repeats
// [RQ16] offset removed before gain multiplication
// [RQ17] register writes act on next results
package adc_corr_pkg;
   localparam int NUM_CH      = 6;
   localparam int WORD_W      = 24;
   localparam int PHASE_W     = 10;
   localparam int CNT_W       = 15;
   localparam int GAIN_FRAC   = 23;
   localparam int DC_SHIFT    = 8;
   localparam int FIFO_DEPTH  = 2;
   localparam int FRAME_W     = (NUM_CH + 1) * WORD_W;
   localparam int ADR_W       = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CLOCK    = 8'h00;
   localparam logic [7:0] OFF_PGA_A    = 8'h04;
   localparam logic [7:0] OFF_PGA_B    = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFF_STATE    = 8'h14;
   localparam logic [7:0] OFF_CH_BASE  = 8'h40;
   localparam int         CH_SHIFT     = 5;
   localparam logic [4:0] CH_CFG       = 5'h00;
   localparam logic [4:0] CH_OFS_HI    = 5'h04;
   localparam logic [4:0] CH_OFS_LO    = 5'h08;
   localparam logic [4:0] CH_GAIN_HI   = 5'h0C;
   localparam logic [4:0] CH_GAIN_LO   = 5'h10;
   // field positions
   localparam int CLK_OSR_LSB = 0;
   localparam int CLK_EN_LSB  = 8;
   localparam int CLK_PWR_LSB = 16;
   localparam int PGA_W       = 3;
   localparam int PGA_STRIDE  = 4;
   localparam int PGA_PER_REG = 4;
   localparam int CFG_MUX_LSB = 0;
   localparam int CFG_DCB_BIT = 2;
   localparam int CFG_PH_LSB  = 6;
   localparam int IRQ_READY   = 0;
   localparam int IRQ_OVF     = 1;
   localparam int IRQ_READ    = 2;
   localparam int IRQ_W       = 3;
   // reset values: ratio 512, all channels on, high resolution
   localparam logic [31:0] CLOCK_RESET = 32'h00023F02;
   localparam logic [15:0] GAIN_HI_RST = 16'h8000;
   localparam logic [CNT_W-1:0] OSR_BASE = 15'h0080;

   typedef enum logic [1:0] {PWR_VERY_LOW, PWR_LOW, PWR_HIGH_RES, PWR_RSVD} power_mode_t;

   typedef struct packed {
      logic [PHASE_W-1:0] phase;
      logic               dcblk;
      logic [1:0]         mux;
   } chan_cfg_t;

   typedef struct packed {
      logic [WORD_W-1:0] offset;
      logic [WORD_W-1:0] gain;
   } chan_cal_t;

   // oversampling ratio from its 3-bit code: 128 << code
   function automatic logic [CNT_W-1:0] osr_of(input logic [2:0] code);
      osr_of = OSR_BASE << code;
   endfunction : osr_of
endpackage : adc_corr_pkg

//--- hdl/chan_correct.sv
// Purpose: per-channel offset or dc-block removal followed by gain trim
// Assumes: gain trim is unsigned 1.23, unity 0x800000
// Notes:   result saturates to 24-bit two's complement, one cycle latency
`timescale 1ns/1ps
module chan_correct (
   // clock and reset
   input  wire logic                            i_clock,
   input  wire logic                            i_rst,
   // raw sample in
   input  wire logic                            i_valid,
   input  wire logic signed [adc_corr_pkg::WORD_W-1:0] i_raw,
   input  wire adc_corr_pkg::chan_cal_t         i_cal,
   input  wire logic                            i_dcblk,
   // corrected sample out
   output logic signed [adc_corr_pkg::WORD_W-1:0] o_data
);
   localparam int W  = adc_corr_pkg::WORD_W;
   localparam int AW = W + adc_corr_pkg::DC_SHIFT;
   localparam int PW = 2 * (W + 1);

   logic signed [AW-1:0] acc_q;
   wire  logic signed [W-1:0]  est     = acc_q[AW-1:adc_corr_pkg::DC_SHIFT];
   wire  logic signed [W:0]    dc_err  = {i_raw[W-1], i_raw} - {est[W-1], est};
   wire  logic signed [W-1:0]  ofs     = i_cal.offset;
   wire  logic signed [W:0]    ofs_err = {i_raw[W-1], i_raw} - {ofs[W-1], ofs};
   wire  logic signed [W:0]    removed = i_dcblk ? dc_err : ofs_err;            // RQ13 RQ9
   wire  logic signed [PW-1:0] prod    = removed * $signed({1'b0, i_cal.gain}); // RQ16 RQ10
   wire  logic signed [PW-1:0] scaled  = prod >>> adc_corr_pkg::GAIN_FRAC;

   function automatic logic [W-1:0] sat(input logic signed [PW-1:0] v);
      logic signed [PW-1:0] hi;
      logic signed [PW-1:0] lo;
      hi = {{(PW-W+1){1'b0}}, {(W-1){1'b1}}};
      lo = -hi - 1;
      if (v > hi) begin
         sat = hi[W-1:0];
      end else if (v < lo) begin
         sat = lo[W-1:0];
      end else begin
         sat = v[W-1:0];
      end
   endfunction : sat

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         acc_q  <= '0;
         o_data <= '0;
      end else if (i_valid) begin
         acc_q  <= acc_q + AW'(dc_err);
         o_data <= sat(scaled);
      end
   end
endmodule : chan_correct

//--- hdl/spi_frame_tx.sv
// Purpose: serial output of one data frame, clock idle low, data changes on rising edge
// Assumes: pins are asynchronous to i_clock and far slower than it
// Notes:   o_done only after every bit of the frame was clocked out
`timescale 1ns/1ps
module spi_frame_tx #(
   parameter int FRAME_W = adc_corr_pkg::FRAME_W
) (
   // clock and reset
   input  wire logic               i_clock,
   input  wire logic               i_rst,
   // pins
   input  wire logic               i_sclk,
   input  wire logic               i_cs_n,
   output logic                    o_miso,
   output logic                    o_miso_oe_n,
   // frame
   input  wire logic [FRAME_W-1:0] i_frame,
   output logic                    o_start,
   output logic                    o_done
);
   localparam int BW = $clog2(FRAME_W + 1);
   localparam logic [BW-1:0] LAST = BW'(FRAME_W - 1);

   logic [2:0]         sclk_s;
   logic [2:0]         cs_s;
   logic               sclk_q;
   logic               cs_q;
   logic               active_q;
   logic [FRAME_W-1:0] sh_q;
   logic [BW-1:0]      bits_q;

   wire logic sclk_new = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_q;
   wire logic cs_new   = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_q;
   wire logic rise     = sclk_new & ~sclk_q;
   wire logic fall     = ~sclk_new & sclk_q;
   wire logic cs_fall  = ~cs_new & cs_q;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sclk_s      <= '0;
         cs_s        <= '1;
         sclk_q      <= 1'b0;
         cs_q        <= 1'b1;
         active_q    <= 1'b0;
         sh_q        <= '0;
         bits_q      <= '0;
         o_miso      <= 1'b0;
         o_miso_oe_n <= 1'b1;
         o_start     <= 1'b0;
         o_done      <= 1'b0;
      end else begin
         sclk_s      <= {sclk_s[1:0], i_sclk};
         cs_s        <= {cs_s[1:0], i_cs_n};
         sclk_q      <= sclk_new;
         cs_q        <= cs_new;
         o_start     <= cs_fall;
         o_done      <= 1'b0;
         o_miso_oe_n <= cs_new;
         if (cs_fall) begin
            active_q <= 1'b1;
            sh_q     <= i_frame;
            bits_q   <= '0;
         end else if (cs_new) begin
            active_q <= 1'b0;
         end else if (active_q && rise) begin
            o_miso <= sh_q[FRAME_W-1];                    // RQ4
            sh_q   <= sh_q << 1;
         end else if (active_q && fall) begin
            bits_q <= bits_q + 1'b1;
            if (bits_q == LAST) begin
               o_done   <= 1'b1;                          // RQ15
               active_q <= 1'b0;
            end
         end
      end
   end
endmodule : spi_frame_tx

//--- tb/adc_corr_asserts.sv
// Purpose: bus, serial pin and reset checks
// Assumes: top-level ports only
// Notes:   bound after endmodule
`timescale 1ns/1ps
module adc_corr_asserts #(
   parameter int NUM_CH = adc_corr_pkg::NUM_CH
) (
   // watched ports
   input wire logic i_clock, i_rst, i_wb_cyc, i_wb_stb, o_wb_ack, i_spi_sclk, i_spi_cs_n,
   input wire logic o_spi_miso, o_spi_miso_oe_n, o_sample_ready_n, o_irq,
   input wire logic [31:0]               o_wb_dat,
   input wire logic [NUM_CH-1:0]         o_chan_enable,
   input wire adc_corr_pkg::power_mode_t o_power_mode
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack too long");
   a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("no ack");
   a_dat_quiet: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("data outside ack");
   a_reset_state: assert property ($fell(i_rst) |-> o_power_mode == adc_corr_pkg::PWR_HIGH_RES
      && &o_chan_enable && !o_irq && o_sample_ready_n) else $error("bad reset state");
   a_oe_select: assert property ($fell(i_spi_cs_n) |-> ##[1:6] !o_spi_miso_oe_n)
      else $error("miso not driven");
   a_oe_idle: assert property (i_spi_cs_n [*6] |-> o_spi_miso_oe_n)
      else $error("miso driven idle");
   a_ready_select: assert property ($fell(i_spi_cs_n) |-> ##[1:8] o_sample_ready_n)
      else $error("ready not cleared");
   a_miso_hold: assert property ((!i_spi_sclk && !i_spi_cs_n) [*8] |=> $stable(o_spi_miso))
      else $error("miso moved");
endmodule : adc_corr_asserts
bind adc_sample_correction_path adc_corr_asserts #(.NUM_CH(NUM_CH)) chk_u (.i_clock(i_clock), .i_rst(i_rst),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_spi_sclk(i_spi_sclk),
   .i_spi_cs_n(i_spi_cs_n), .o_spi_miso(o_spi_miso), .o_spi_miso_oe_n(o_spi_miso_oe_n), .o_irq(o_irq),
   .o_sample_ready_n(o_sample_ready_n), .o_wb_dat(o_wb_dat), .o_chan_enable(o_chan_enable),
   .o_power_mode(o_power_mode));

//--- tb/spi_host_model.sv
// Purpose: host side: master clock source and frame reader
// Assumes: bench clock 50 MHz, master clock 6.25 MHz
// Notes:   serial clock phases of six bench cycles
`timescale 1ns/1ps
module spi_host_model (
   // bench side
   input  wire logic    i_clock,
   input  wire logic    i_go,
   output logic         o_busy = 1'b0,
   output logic [167:0] o_frame = '0,
   // pins
   output logic         o_mclk = 1'b0,
   output logic         o_sclk = 1'b0,
   output logic         o_cs_n = 1'b1,
   input  wire logic    i_miso
);
   logic [1:0] div_q = 2'h0;
   always @(posedge i_clock) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) o_mclk <= ~o_mclk;
   end
   // whole frame, idle-low clock, capture at each falling edge
   always @(posedge i_go) begin
      o_busy <= 1'b1;
      o_cs_n <= 1'b0;
      repeat (12) @(posedge i_clock);
      for (int b = 0; b < 168; b++) begin
         o_sclk <= 1'b1;
         repeat (6) @(posedge i_clock);
         o_frame <= {o_frame[166:0], i_miso};
         o_sclk <= 1'b0;
         repeat (6) @(posedge i_clock);
      end
      o_cs_n <= 1'b1;
      o_busy <= 1'b0;
   end
endmodule : spi_host_model

//--- tb/adc_sample_correction_path_bench.sv
// Purpose: self-checking bench of the sample correction path
// Assumes: host model reads whole frames
// Notes:   register rows, then frames, irq, overflow, reset
`timescale 1ns/1ps
module adc_sample_correction_path_bench;
   logic i_clock = 1'b0, i_rst = 1'b1, cyc = 1'b0, we = 1'b0, go = 1'b0, p;
   logic busy, ack, mclk, sclk, cs_n, miso, oe_n, rdy_n, irq;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, r;
   logic [5:0][23:0] raw = {24'h0AAAAA, 24'h7FFFFF, 24'h123456, 24'h000600, 24'h002000, 24'h001100};
   logic [5:0][2:0] pga;
   logic [5:0][1:0] mux;
   logic [5:0] en;
   adc_corr_pkg::power_mode_t pwr;
   logic [167:0] frame;
   int fails = 0, tests_run = 0, n;
   // address and value, read back unchanged; half gain trims undo a gain of two
   logic [39:0] rows [9] = '{40'h00_00021F01, 40'h04_00000421, 40'h08_00000012, 40'h10_00000001,
      40'h40_00000001, 40'h44_00000001, 40'h6C_00004000, 40'h84_00000002, 40'h8C_00004000};
   always #10 i_clock = ~i_clock;
   adc_sample_correction_path dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_master_clock_input(mclk), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .o_spi_miso(miso),
      .o_spi_miso_oe_n(oe_n), .o_sample_ready_n(rdy_n), .i_raw_data(raw), .o_pga_gain(pga),
      .o_chan_mux(mux), .o_chan_enable(en), .o_power_mode(pwr), .o_irq(irq));
   spi_host_model host_u (.i_clock(i_clock), .i_go(go), .o_busy(busy), .o_frame(frame), .o_mclk(mclk),
      .o_sclk(sclk), .o_cs_n(cs_n), .i_miso(miso));
   task automatic check(input logic [167:0] seen, input logic [167:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   task automatic bound(input int lim);
      if (n >= lim) begin
         fails++;
         test_done();
      end
   endtask : bound
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (n = 0; n < 50 && ack !== 1'b1; n++) @(posedge i_clock);
      r = rdat;
      bound(50);
      cyc <= 1'b0;
      @(posedge i_clock);
   endtask : wb
   task automatic wait_fall();
      p = 1'b0;
      for (n = 0; n < 20000 && !(p === 1'b1 && rdy_n === 1'b0); n++) begin
         p = rdy_n;
         @(posedge i_clock);
      end
      bound(20000);
   endtask : wait_fall
   task automatic read_frame();
      go <= 1'b1;
      repeat (2) @(posedge i_clock);
      go <= 1'b0;
      for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge i_clock);
      bound(3000);
   endtask : read_frame
   task automatic do_reset();
      i_rst <= 1'b1;
      repeat (6) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      check({rdy_n, oe_n, irq, ack, mux, en, pwr}, {4'hC, 12'h0, 6'h3F, adc_corr_pkg::PWR_HIGH_RES});
   endtask : do_reset
   initial begin
      do_reset();
      wb(1'b0, 8'h00, 32'h0);
      check(r, adc_corr_pkg::CLOCK_RESET);
      for (int i = 0; i < 9; i++) begin
         wb(1'b1, rows[i][39:32], rows[i][31:0]);
         wb(1'b0, rows[i][39:32], 32'h0);
         check(r, rows[i][31:0]);
      end
      wb(1'b0, 8'h30, 32'h0);
      check(r, 32'h0);
      check({mux[0], pga[2], pga[0], en, pwr}, {2'h1, 3'h4, 3'h1, 6'h1F, adc_corr_pkg::PWR_HIGH_RES});
      repeat (3) begin
         wait_fall();
         read_frame();
      end
      // disabled channel reads zero
      check(frame[149:0], {6'h1F, 24'h0, 24'h7FFFFF, 24'h123456, 24'h200, 24'h1000, 24'h1000});
      check(irq, 1'b1);
      wb(1'b1, 8'h10, 32'h2);
      wb(1'b1, 8'h0C, 32'h7);
      check(irq, 1'b0);
      // left unread: two frames fill, then one ready every two periods
      repeat (3) wait_fall();
      repeat (2) begin
         wait_fall();
         check(n inside {[8190:8194]}, 1'b1);
      end
      wb(1'b0, 8'h0C, 32'h0);
      check({irq, r[1]}, 2'h3);
      do_reset();
      test_done();
   end
endmodule : adc_sample_correction_path_bench
